// >>> logic/icw_pkg.sv
package icw_pkg;
  // ----------------------------------------------------------------
  // Device-control register numbers
  // ----------------------------------------------------------------
  localparam logic [9:0]  ICW_MEM_INDEX    = 10'h010;
  localparam logic [9:0]  ICW_MEM_DATA     = 10'h011;
  localparam logic [9:0]  ICW_PB_INDEX     = 10'h012;
  localparam logic [9:0]  ICW_PB_DATA      = 10'h013;
  localparam logic [9:0]  ICW_DC_INDEX     = 10'h014;
  localparam logic [9:0]  ICW_DC_DATA      = 10'h015;
  // ----------------------------------------------------------------
  // Memory controller offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] ICW_MEM_SYN0     = 32'h00;
  localparam logic [31:0] ICW_MEM_SYN1     = 32'h08;
  localparam logic [31:0] ICW_MEM_ERRADDR  = 32'h10;
  localparam logic [31:0] ICW_MEM_OPTIONS  = 32'h20;
  localparam logic [31:0] ICW_MEM_STATUS   = 32'h24;
  localparam logic [31:0] ICW_MEM_REFRESH  = 32'h30;
  localparam logic [31:0] ICW_MEM_IDLE     = 32'h34;
  localparam logic [27:0] ICW_MEM_BANK_BLK = 28'h4;
  localparam logic [31:0] ICW_MEM_TIMING   = 32'h80;
  localparam logic [31:0] ICW_MEM_ECCCFG   = 32'h94;
  localparam logic [31:0] ICW_MEM_ECCSTAT  = 32'h98;
  // ----------------------------------------------------------------
  // Peripheral bus controller offsets
  // ----------------------------------------------------------------
  localparam logic [28:0] ICW_PB_BCR_BLK   = 29'h0;
  localparam logic [28:0] ICW_PB_BAP_BLK   = 29'h2;
  localparam logic [31:0] ICW_PB_ERRADDR   = 32'h20;
  localparam logic [31:0] ICW_PB_ERRST0    = 32'h21;
  localparam logic [31:0] ICW_PB_ERRST1    = 32'h22;
  localparam logic [31:0] ICW_PB_CONFIG    = 32'h23;
  // ----------------------------------------------------------------
  // Decompression controller offsets
  // ----------------------------------------------------------------
  localparam logic [29:0] ICW_DC_ORIG_BLK  = 30'h0;
  localparam logic [31:0] ICW_DC_ADEC0     = 32'h04;
  localparam logic [31:0] ICW_DC_ADEC1     = 32'h05;
  localparam logic [31:0] ICW_DC_CONFIG    = 32'h40;
  localparam logic [31:0] ICW_DC_IDENT     = 32'h41;
  localparam logic [31:0] ICW_DC_VERSION   = 32'h42;
  localparam logic [31:0] ICW_DC_BUSADDR   = 32'h50;
  localparam logic [31:0] ICW_DC_MEMADDR   = 32'h51;
  localparam logic [31:0] ICW_DC_ERRSTAT   = 32'h52;
  localparam logic [21:0] ICW_DC_TABLE_BLK = 22'h1;
  localparam int          ICW_DC_TABLE_LEN = 1024;
  localparam logic [31:0] ICW_RESET_WORD   = 32'h0;

  typedef struct packed {
    logic [31:0] memSyn0;
    logic [31:0] memSyn1;
    logic [31:0] memEcc;
    logic [31:0] dcErr;
  } icw_err_t;

  typedef struct packed {
    logic [31:0] memOptions;
    logic [31:0] pbConfig;
    logic [31:0] dcConfig;
  } icw_cfg_t;

  typedef struct packed {
    logic [31:0]       memIndex;
    logic [31:0]       pbIndex;
    logic [31:0]       dcIndex;
    logic [31:0]       memSyn0;
    logic [31:0]       memSyn1;
    logic [31:0]       memErrAddr;
    logic [31:0]       memRefresh;
    logic [31:0]       memIdle;
    logic [3:0][31:0]  memBank;
    logic [31:0]       memTiming;
    logic [31:0]       memEccCfg;
    logic [31:0]       memEccStat;
    logic [7:0][31:0]  pbBank;
    logic [7:0][31:0]  pbAccess;
    logic [31:0]       pbErrAddr;
    logic [31:0]       pbErrSt0;
    logic [31:0]       pbErrSt1;
    logic [3:0][31:0]  dcOrigin;
    logic [1:0][31:0]  dcAddrDec;
    logic [31:0]       dcErrStat;
    icw_cfg_t          cfg;
    logic [31:0]       rdData;
    logic              ack;
  } icw_state_t;
endpackage

// >>> logic/icw_window.sv
`timescale 1ns/1ps
module icw_window import icw_pkg::*; #(
  parameter logic [31:0] DcIdentCode   = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] DcVersionCode = 32'h0000_0001  // arbitrary value
) (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  // Device-control moves
  input  wire logic        dcrRead,
  input  wire logic        dcrWrite,
  input  wire logic [9:0]  dcrAddr,
  input  wire logic [31:0] dcrWrData,
  output logic      [31:0] dcrRdData,
  output logic             dcrAck,
  // Controller state in, configuration out
  input  wire icw_err_t    errSet,
  input  wire logic [31:0] memStatus,
  input  wire logic [31:0] dcBusErrAddr,
  input  wire logic [31:0] dcMemErrAddr,
  output icw_cfg_t         cfgOut
);
  icw_state_t  s_r;
  icw_state_t  s_nxt;
  logic [31:0] tableMem [ICW_DC_TABLE_LEN];
  logic        tableWe;
  logic [31:0] rd;
  logic        wrMem;
  logic        wrPb;
  logic        wrDc;
  logic [9:0]  tIdx;

  assign tIdx = s_r.dcIndex[9:0];

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd = ICW_RESET_WORD;
    unique case (dcrAddr)
      ICW_MEM_INDEX: rd = s_r.memIndex;
      ICW_PB_INDEX:  rd = s_r.pbIndex;
      ICW_DC_INDEX:  rd = s_r.dcIndex;
      ICW_MEM_DATA: begin
        if (s_r.memIndex[31:4] == ICW_MEM_BANK_BLK && s_r.memIndex[1:0] == 2'h0) begin
          rd = s_r.memBank[s_r.memIndex[3:2]];
        end else begin
          case (s_r.memIndex)
            ICW_MEM_SYN0:    rd = s_r.memSyn0;
            ICW_MEM_SYN1:    rd = s_r.memSyn1;
            ICW_MEM_ERRADDR: rd = s_r.memErrAddr;
            ICW_MEM_OPTIONS: rd = s_r.cfg.memOptions;
            ICW_MEM_STATUS:  rd = memStatus;
            ICW_MEM_REFRESH: rd = s_r.memRefresh;
            ICW_MEM_IDLE:    rd = s_r.memIdle;
            ICW_MEM_TIMING:  rd = s_r.memTiming;
            ICW_MEM_ECCCFG:  rd = s_r.memEccCfg;
            ICW_MEM_ECCSTAT: rd = s_r.memEccStat;
            default:         rd = ICW_RESET_WORD;
          endcase
        end
      end
      ICW_PB_DATA: begin
        if (s_r.pbIndex[31:3] == ICW_PB_BCR_BLK) begin
          rd = s_r.pbBank[s_r.pbIndex[2:0]];
        end else if (s_r.pbIndex[31:3] == ICW_PB_BAP_BLK) begin
          rd = s_r.pbAccess[s_r.pbIndex[2:0]];
        end else begin
          case (s_r.pbIndex)
            ICW_PB_ERRADDR: rd = s_r.pbErrAddr;
            ICW_PB_ERRST0:  rd = s_r.pbErrSt0;
            ICW_PB_ERRST1:  rd = s_r.pbErrSt1;
            ICW_PB_CONFIG:  rd = s_r.cfg.pbConfig;
            default:        rd = ICW_RESET_WORD;
          endcase
        end
      end
      ICW_DC_DATA: begin
        if (s_r.dcIndex[31:2] == ICW_DC_ORIG_BLK) begin
          rd = s_r.dcOrigin[s_r.dcIndex[1:0]];
        end else if (s_r.dcIndex[31:10] == ICW_DC_TABLE_BLK) begin
          rd = tableMem[tIdx];
        end else begin
          case (s_r.dcIndex)
            ICW_DC_ADEC0:   rd = s_r.dcAddrDec[0];
            ICW_DC_ADEC1:   rd = s_r.dcAddrDec[1];
            ICW_DC_CONFIG:  rd = s_r.cfg.dcConfig;
            ICW_DC_IDENT:   rd = DcIdentCode;
            ICW_DC_VERSION: rd = DcVersionCode;
            ICW_DC_BUSADDR: rd = dcBusErrAddr;
            ICW_DC_MEMADDR: rd = dcMemErrAddr;
            ICW_DC_ERRSTAT: rd = s_r.dcErrStat;
            default:        rd = ICW_RESET_WORD;
          endcase
        end
      end
      default: rd = ICW_RESET_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Write decode and next state
  // ----------------------------------------------------------------
  assign wrMem = dcrWrite && dcrAddr == ICW_MEM_DATA;
  assign wrPb  = dcrWrite && dcrAddr == ICW_PB_DATA;
  assign wrDc  = dcrWrite && dcrAddr == ICW_DC_DATA;
  assign tableWe = wrDc && s_r.dcIndex[31:10] == ICW_DC_TABLE_BLK;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = dcrRead || dcrWrite;
    if (dcrRead) begin
      s_nxt.rdData = rd;
    end
    if (dcrWrite && dcrAddr == ICW_MEM_INDEX) begin
      s_nxt.memIndex = dcrWrData;
    end
    if (dcrWrite && dcrAddr == ICW_PB_INDEX) begin
      s_nxt.pbIndex = dcrWrData;
    end
    if (dcrWrite && dcrAddr == ICW_DC_INDEX) begin
      s_nxt.dcIndex = dcrWrData;
    end
    if (wrMem) begin
      if (s_r.memIndex[31:4] == ICW_MEM_BANK_BLK && s_r.memIndex[1:0] == 2'h0) begin
        s_nxt.memBank[s_r.memIndex[3:2]] = dcrWrData;
      end else begin
        case (s_r.memIndex)
          ICW_MEM_SYN0:    s_nxt.memSyn0 = s_r.memSyn0 & ~dcrWrData;
          ICW_MEM_SYN1:    s_nxt.memSyn1 = s_r.memSyn1 & ~dcrWrData;
          ICW_MEM_ERRADDR: s_nxt.memErrAddr = dcrWrData;
          ICW_MEM_OPTIONS: s_nxt.cfg.memOptions = dcrWrData;
          ICW_MEM_REFRESH: s_nxt.memRefresh = dcrWrData;
          ICW_MEM_IDLE:    s_nxt.memIdle = dcrWrData;
          ICW_MEM_TIMING:  s_nxt.memTiming = dcrWrData;
          ICW_MEM_ECCCFG:  s_nxt.memEccCfg = dcrWrData;
          ICW_MEM_ECCSTAT: s_nxt.memEccStat = s_r.memEccStat & ~dcrWrData;
          default:         s_nxt.memTiming = s_r.memTiming;
        endcase
      end
    end
    if (wrPb) begin
      if (s_r.pbIndex[31:3] == ICW_PB_BCR_BLK) begin
        s_nxt.pbBank[s_r.pbIndex[2:0]] = dcrWrData;
      end else if (s_r.pbIndex[31:3] == ICW_PB_BAP_BLK) begin
        s_nxt.pbAccess[s_r.pbIndex[2:0]] = dcrWrData;
      end else begin
        case (s_r.pbIndex)
          ICW_PB_ERRADDR: s_nxt.pbErrAddr = dcrWrData;
          ICW_PB_ERRST0:  s_nxt.pbErrSt0 = dcrWrData;
          ICW_PB_ERRST1:  s_nxt.pbErrSt1 = dcrWrData;
          ICW_PB_CONFIG:  s_nxt.cfg.pbConfig = dcrWrData;
          default:        s_nxt.pbErrAddr = s_r.pbErrAddr;
        endcase
      end
    end
    // decompression window write, read-only offsets ignored
    if (wrDc) begin
      if (s_r.dcIndex[31:2] == ICW_DC_ORIG_BLK) begin
        s_nxt.dcOrigin[s_r.dcIndex[1:0]] = dcrWrData;
      end else begin
        case (s_r.dcIndex)
          ICW_DC_ADEC0:   s_nxt.dcAddrDec[0] = dcrWrData;
          ICW_DC_ADEC1:   s_nxt.dcAddrDec[1] = dcrWrData;
          ICW_DC_CONFIG:  s_nxt.cfg.dcConfig = dcrWrData;
          ICW_DC_ERRSTAT: s_nxt.dcErrStat = s_r.dcErrStat & ~dcrWrData;
          default:        s_nxt.dcErrStat = s_nxt.dcErrStat;
        endcase
      end
    end
    // sticky error bits, set wins over a same-cycle clear
    s_nxt.memSyn0    = s_nxt.memSyn0 | errSet.memSyn0;
    s_nxt.memSyn1    = s_nxt.memSyn1 | errSet.memSyn1;
    s_nxt.memEccStat = s_nxt.memEccStat | errSet.memEcc;
    s_nxt.dcErrStat  = s_nxt.dcErrStat | errSet.dcErr;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  // Table has no reset: a 1024-word array is far too costly to clear
  always_ff @(posedge sys_clk) begin
    if (clkEn && tableWe) begin
      tableMem[tIdx] <= dcrWrData;
    end
  end

  assign dcrRdData = s_r.rdData;
  assign dcrAck    = s_r.ack;
  assign cfgOut    = s_r.cfg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence tableWr;
    clkEn && tableWe;
  endsequence
  // A second table write before the read would hide the first one
  sequence tableQuiet;
    !(clkEn && tableWe);
  endsequence
  sequence tableRdSame;
    clkEn && dcrRead && dcrAddr == ICW_DC_DATA && $stable(s_r.dcIndex);
  endsequence

  a_mem_index_load: assert property (
    clkEn && dcrWrite && dcrAddr == ICW_MEM_INDEX |=> s_r.memIndex == $past(dcrWrData)
  ) else $error("memory index not loaded");
  a_pb_cfg_write: assert property (
    clkEn && wrPb && s_r.pbIndex == ICW_PB_CONFIG |=> cfgOut.pbConfig == $past(dcrWrData)
  ) else $error("peripheral configuration not written");
  a_dc_index_load: assert property (
    clkEn && dcrWrite && dcrAddr == ICW_DC_INDEX |=> s_r.dcIndex == $past(dcrWrData)
  ) else $error("decompression index not loaded");
  a_mem_status_read: assert property (
    clkEn && dcrRead && dcrAddr == ICW_MEM_DATA && s_r.memIndex == ICW_MEM_STATUS
    |=> dcrAck && dcrRdData == $past(memStatus)
  ) else $error("memory status read wrong");
  a_pb_access_rw: assert property (
    clkEn && wrPb && s_r.pbIndex == 32'h15 |=> s_r.pbAccess[5] == $past(dcrWrData)
  ) else $error("access parameters not written");
  a_table_round: assert property (
    tableWr ##1 tableQuiet ##1 tableRdSame |=> dcrRdData == $past(dcrWrData, 3)
  ) else $error("decode table readback wrong");
  a_version_ro: assert property (
    clkEn && dcrRead && dcrAddr == ICW_DC_DATA && s_r.dcIndex == ICW_DC_VERSION
    |=> dcrRdData == DcVersionCode
  ) else $error("version read wrong");
  a_err_set_wins: assert property (
    clkEn && errSet.dcErr[0] |=> s_r.dcErrStat[0]
  ) else $error("error event lost");
  a_index_hold: assert property (
    clkEn && !(dcrWrite && dcrAddr == ICW_PB_INDEX) |=> $stable(s_r.pbIndex)
  ) else $error("peripheral index changed");
  a_unmapped_zero: assert property (
    clkEn && dcrRead && dcrAddr == ICW_MEM_DATA && s_r.memIndex == 32'h04
    |=> dcrRdData == 32'h0
  ) else $error("unmapped offset read nonzero");
endmodule

// >>> verif/icw_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Processor side issuing device-control moves
// ------------------------------------------------------------
module icw_core_model (
  // Clock
  input  wire logic        sys_clk,
  // Requests
  output logic             dcrRead,
  output logic             dcrWrite,
  output logic      [9:0]  dcrAddr,
  output logic      [31:0] dcrWrData,
  // Answers
  input  wire logic [31:0] dcrRdData,
  input  wire logic        dcrAck
);
  int idleCycles = 0;
  int missedAcks = 0;

  initial begin
    dcrRead   = 1'b0;
    dcrWrite  = 1'b0;
    dcrAddr   = 10'h3ff;
    dcrWrData = 32'h0;
  end

  // move to or from one register
  task automatic move(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    repeat (idleCycles) @(posedge sys_clk);
    @(posedge sys_clk);
    dcrWrite  <= w;
    dcrRead   <= ~w;
    dcrAddr   <= a;
    dcrWrData <= d;
    // Request is level sampled, so it stands for exactly one edge
    @(posedge sys_clk);
    dcrWrite  <= 1'b0;
    dcrRead   <= 1'b0;
    // Released lines flip so a stale value never looks valid
    dcrAddr   <= ~a;
    dcrWrData <= ~d;
    @(negedge sys_clk);
    if (dcrAck !== 1'b1) begin
      missedAcks++;
    end
    q = dcrRdData;
  endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %0t got %h expected %h", $time, (got), (exp)); end end
module tb_top import icw_pkg::*;;
  localparam logic [31:0] IdentVal   = 32'h0000_00c3; // arbitrary value
  localparam logic [31:0] VersionVal = 32'h0000_0021; // arbitrary value
  localparam logic [11:0] MemOffs[10] = '{12'h010, 12'h020, 12'h030, 12'h034, 12'h040,
                                          12'h044, 12'h048, 12'h04c, 12'h080, 12'h094};
  localparam logic [13:0] ClrRegs[4] = '{14'h0000, 14'h0008, 14'h0098, 14'h2052};
  localparam logic [13:0] NoRegs[5]  = '{14'h0004, 14'h0041, 14'h1008, 14'h2006, 14'h23ff};
  logic        sys_clk      = 1'b0;
  logic        reset        = 1'b1;
  logic        clkEn        = 1'b1;
  icw_err_t    errSet       = '0;
  logic [31:0] memStatus    = 32'h5a5a_0f0f;
  logic [31:0] dcBusErrAddr = 32'h1234_5678;
  logic [31:0] dcMemErrAddr = 32'h8765_4321;
  logic        dcrRead;
  logic        dcrWrite;
  logic        dcrAck;
  logic [9:0]  dcrAddr;
  logic [31:0] dcrWrData;
  logic [31:0] dcrRdData;
  logic [31:0] q;
  icw_cfg_t    cfgOut;
  logic [13:0] regs[$];
  int          mismatches   = 0;
  int          nCompared    = 0;

  always #25 sys_clk = ~sys_clk;

  icw_window #(.DcIdentCode(IdentVal), .DcVersionCode(VersionVal)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .dcrRead(dcrRead),
    .dcrWrite(dcrWrite), .dcrAddr(dcrAddr), .dcrWrData(dcrWrData),
    .dcrRdData(dcrRdData), .dcrAck(dcrAck), .errSet(errSet), .memStatus(memStatus),
    .dcBusErrAddr(dcBusErrAddr), .dcMemErrAddr(dcMemErrAddr), .cfgOut(cfgOut));

  icw_core_model core_u (
    .sys_clk(sys_clk), .dcrRead(dcrRead), .dcrWrite(dcrWrite), .dcrAddr(dcrAddr),
    .dcrWrData(dcrWrData), .dcrRdData(dcrRdData), .dcrAck(dcrAck));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] pat(input logic [13:0] e);
    return {~{2'b00, e}, {2'b00, e}};
  endfunction

  function automatic logic [9:0] dn(input logic [13:0] e);
    return ICW_MEM_DATA + {7'h0, e[13:12], 1'b0};
  endfunction

  task automatic acc(input logic w, input logic [13:0] e, input logic [31:0] d);
    core_u.move(1'b1, dn(e) - 10'h1, {20'h0, e[11:0]}, q);
    core_u.move(w, dn(e), d, q);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (MemOffs[i]) regs.push_back({2'd0, MemOffs[i]});
    for (int i = 0; i < 8; i++) begin
      regs.push_back({2'd1, 12'(i)});
      regs.push_back({2'd1, 12'(i + 16)});
    end
    for (int i = 0; i < 4; i++) regs.push_back({2'd1, 12'(i + 32)});
    for (int i = 0; i < 6; i++) regs.push_back({2'd2, 12'(i)});
    regs.push_back(14'h2040);
    regs.push_back(14'h2400);
    regs.push_back(14'h27ff);
    core_u.move(1'b0, ICW_DC_INDEX, 32'h0, q);
    `CHK(q, 32'h0)
    foreach (regs[i]) begin
      acc(1'b1, regs[i], pat(regs[i]));
      core_u.move(1'b0, dn(regs[i]), 32'h0, q);
      `CHK(q, pat(regs[i]))
    end
    // Slow requester on the second pass, also proves no aliasing
    core_u.idleCycles = 2;
    foreach (regs[i]) begin
      acc(1'b0, regs[i], 32'h0);
      `CHK(q, pat(regs[i]))
    end
    core_u.idleCycles = 0;
    `CHK(cfgOut, {pat(14'h0020), pat(14'h1023), pat(14'h2040)})
    // Read-only places ignore writes
    acc(1'b1, 14'h0024, 32'hffff_ffff);
    acc(1'b1, 14'h2041, 32'hffff_ffff);
    acc(1'b1, 14'h2050, 32'hffff_ffff);
    acc(1'b0, 14'h0024, 32'h0);
    `CHK(q, memStatus)
    acc(1'b0, 14'h2041, 32'h0);
    `CHK(q, IdentVal)
    acc(1'b0, 14'h2042, 32'h0);
    `CHK(q, VersionVal)
    acc(1'b0, 14'h2050, 32'h0);
    `CHK(q, dcBusErrAddr)
    acc(1'b0, 14'h2051, 32'h0);
    `CHK(q, dcMemErrAddr)
    // Sticky errors, cleared by software one bit group at a time
    @(posedge sys_clk);
    errSet <= {4{32'h0000_00a5}};
    @(posedge sys_clk);
    errSet <= '0;
    foreach (ClrRegs[i]) begin
      acc(1'b0, ClrRegs[i], 32'h0);
      `CHK(q, 32'h0000_00a5)
      acc(1'b1, ClrRegs[i], 32'h0000_0005);
      acc(1'b0, ClrRegs[i], 32'h0);
      `CHK(q, 32'h0000_00a0)
    end
    // Error event beats a clear of the same bit in one cycle
    fork
      core_u.move(1'b1, ICW_DC_DATA, 32'h0000_00a1, q);
      begin
        @(posedge sys_clk);
        errSet.dcErr <= 32'h0000_0001;
        @(posedge sys_clk);
        errSet <= '0;
      end
    join
    core_u.move(1'b0, ICW_DC_DATA, 32'h0, q);
    `CHK(q, 32'h0000_0001)
    foreach (NoRegs[i]) begin
      acc(1'b1, NoRegs[i], 32'hffff_ffff);
      acc(1'b0, NoRegs[i], 32'h0);
      `CHK(q, 32'h0)
    end
    // Upper index bits set must not alias onto the options register
    core_u.move(1'b1, ICW_MEM_INDEX, 32'h8000_0020, q);
    core_u.move(1'b1, ICW_MEM_DATA, 32'h0, q);
    core_u.move(1'b0, ICW_MEM_DATA, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK(cfgOut.memOptions, pat(14'h0020))
    core_u.move(1'b0, 10'h016, 32'h0, q);
    `CHK(q, 32'h0)
    // Frozen enable: the move is neither taken nor answered
    @(posedge sys_clk);
    clkEn <= 1'b0;
    core_u.move(1'b1, ICW_PB_INDEX, 32'h0000_0007, q);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    core_u.move(1'b0, ICW_PB_INDEX, 32'h0, q);
    `CHK(q, 32'h0000_0008)
    // Second reset in mid-run
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(cfgOut, 96'h0)
    reset <= 1'b0;
    core_u.move(1'b0, ICW_PB_INDEX, 32'h0, q);
    `CHK(q, 32'h0)
    acc(1'b0, 14'h0020, 32'h0);
    `CHK(q, 32'h0)
    // Only the frozen move went unanswered
    `CHK(core_u.missedAcks, 1)
    end_sim();
  end
endmodule
